// >>> hw/aalo_core.sv
// arithmetic and logic execution datapath with i/o address mapping
// assumes the decoder fetches operands and writes results back; one clock, synchronous reset
//
// Chosen here: the register offsets and the address-and-strobe port.

`timescale 1ns/1ns

module aalo_core (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // operation request
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] dst_lo,
  input wire logic [7:0] dst_hi,
  input wire logic [7:0] source_register,
  input wire logic [7:0] imm,
  // operation result
  output logic res_valid,
  output logic [7:0] res_lo,
  output logic [7:0] res_hi,
  output logic res_wr_lo,
  output logic res_wr_hi,
  output logic res_to_r0,
  output logic busy,
  output logic [7:0] status_flags,
  // i/o access mapping
  input wire logic io_valid,
  input wire logic [2:0] io_kind,
  input wire logic [7:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_cur_value,
  output logic io_ack,
  output logic io_legal,
  output logic [7:0] io_data_addr,
  output logic [7:0] io_wmask,
  output logic [7:0] io_wvalue,
  output logic io_skip,
  // software register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import aalo_pkg::*;

  // ==================================================
  // operand selection and shared adders
  aalo_state_e state;
  logic [7:0] opa;
  logic [7:0] opb;
  logic cin;
  logic [8:0] add9;
  logic [4:0] add_nib;
  logic [8:0] sub9;
  logic [4:0] sub_nib;
  logic [16:0] word17;
  logic signed [17:0] prod;
  logic [7:0] r8;
  logic [15:0] r16;
  logic wide;
  logic [7:0] upd;
  logic [7:0] nf;
  logic two_clk;
  logic next_wr_hi;
  logic next_to_r0;
  logic issue;
  logic [7:0] op_count;

  assign issue = op_valid && (state == SEQ_IDLE);

  always_comb begin
    opa = dst_lo;
    opb = source_register;
    cin = 1'b0;
    case (op_code)
      OP_SUB_CONSTANT, OP_AND_CONSTANT, OP_OR_CONSTANT, OP_MASK_SET_BITS: opb = imm;
      OP_SUB_CARRY_CONSTANT: begin
        opb = imm;
        cin = status_flags[FLAG_C];
      end
      OP_ADD_CARRY, OP_SUB_WITH_BORROW: cin = status_flags[FLAG_C];
      OP_INCREMENT, OP_DECREMENT: opb = 8'h01;
      OP_TWOS_COMPLEMENT: begin
        opa = ALL_ZERO;
        opb = dst_lo;
      end
      OP_MASK_CLEAR_BITS: opb = ALL_ONES - imm;
      OP_ZERO_MINUS_TEST, OP_REGISTER_ZERO: opb = dst_lo;
      default: opb = source_register;
    endcase
  end

  // the word adder and multiplier are shared with nothing: they sit on the two-clock path
  assign add9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  assign add_nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign sub9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  assign sub_nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
  assign word17 = (op_code == OP_WORD_SUB_IMMEDIATE) ?
    ({1'b0, dst_hi, dst_lo} - {11'h000, imm[5:0]}) : ({1'b0, dst_hi, dst_lo} + {11'h000, imm[5:0]});
  assign prod = $signed({(op_code != OP_UNSIGNED_PRODUCT) && dst_lo[7], dst_lo})
    * $signed({(op_code == OP_SIGNED_PRODUCT) && source_register[7], source_register});

  // ==================================================
  // result and flag selection
  always_comb begin
    r8 = dst_lo;
    r16 = {dst_hi, dst_lo};
    wide = 1'b0;
    upd = 8'h00;
    nf = status_flags;
    two_clk = 1'b0;
    next_wr_hi = 1'b0;
    next_to_r0 = 1'b0;
    case (op_code)
      OP_ADD, OP_ADD_CARRY: begin
        r8 = add9[7:0];
        nf[FLAG_C] = add9[8];
        nf[FLAG_H] = add_nib[4];
        nf[FLAG_V] = (opa[7] == opb[7]) && (add9[7] != opa[7]);
        upd = 8'h2f;
      end
      OP_INCREMENT: begin
        r8 = add9[7:0];
        nf[FLAG_V] = (opa[7] == opb[7]) && (add9[7] != opa[7]);
        upd = 8'h0e;
      end
      OP_SUB, OP_SUB_CONSTANT, OP_SUB_WITH_BORROW, OP_SUB_CARRY_CONSTANT, OP_TWOS_COMPLEMENT: begin
        r8 = sub9[7:0];
        nf[FLAG_C] = sub9[8];
        nf[FLAG_H] = sub_nib[4];
        nf[FLAG_V] = (opa[7] != opb[7]) && (sub9[7] != opa[7]);
        upd = 8'h2f;
      end
      OP_DECREMENT: begin
        r8 = sub9[7:0];
        nf[FLAG_V] = (opa[7] != opb[7]) && (sub9[7] != opa[7]);
        upd = 8'h0e;
      end
      OP_WORD_ADD_IMMEDIATE: begin
        r16 = word17[15:0];
        wide = 1'b1;
        two_clk = 1'b1;
        next_wr_hi = 1'b1;
        nf[FLAG_C] = word17[16];
        nf[FLAG_V] = !dst_hi[7] && word17[15];
        nf[FLAG_S] = word17[15] ^ nf[FLAG_V];
        upd = 8'h1f;
      end
      OP_WORD_SUB_IMMEDIATE: begin
        r16 = word17[15:0];
        wide = 1'b1;
        two_clk = 1'b1;
        next_wr_hi = 1'b1;
        nf[FLAG_C] = word17[16];
        nf[FLAG_V] = dst_hi[7] && !word17[15];
        nf[FLAG_S] = word17[15] ^ nf[FLAG_V];
        upd = 8'h1f;
      end
      OP_AND, OP_AND_CONSTANT, OP_MASK_CLEAR_BITS, OP_ZERO_MINUS_TEST: begin
        r8 = opa & opb;
        nf[FLAG_V] = 1'b0;
        upd = 8'h0e;
      end
      OP_OR, OP_OR_CONSTANT, OP_MASK_SET_BITS: begin
        r8 = opa | opb;
        nf[FLAG_V] = 1'b0;
        upd = 8'h0e;
      end
      OP_EXCLUSIVE_OR_REGS, OP_REGISTER_ZERO: begin
        r8 = opa ^ opb;
        nf[FLAG_V] = 1'b0;
        upd = 8'h0e;
      end
      OP_ONES_COMPLEMENT: begin
        r8 = ALL_ONES - dst_lo;
        nf[FLAG_C] = 1'b1;
        nf[FLAG_V] = 1'b0;
        upd = 8'h0f;
      end
      OP_REGISTER_ONES: r8 = ALL_ONES;
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT: begin
        r16 = prod[15:0];
        wide = 1'b1;
        two_clk = 1'b1;
        next_wr_hi = 1'b1;
        next_to_r0 = 1'b1;
        nf[FLAG_C] = prod[15];
        upd = 8'h03;
      end
      default: r8 = dst_lo;
    endcase
    if (!wide) begin
      r16 = {dst_hi, r8};
    end
    nf[FLAG_Z] = wide ? (r16 == 16'h0000) : (r8 == ALL_ZERO);
    nf[FLAG_N] = wide ? r16[15] : r8[7];
  end

  // ==================================================
  // sequencer: two-clock ops hold the result one extra cycle
  logic [15:0] pend_res;
  logic [7:0] pend_flags;
  logic [7:0] pend_upd;
  logic pend_hi;
  logic pend_r0;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SEQ_IDLE;
      busy <= 1'b0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (issue && two_clk) begin
            state <= SEQ_SECOND;
            busy <= 1'b1;
          end
        end
        SEQ_SECOND: begin
          state <= SEQ_IDLE;
          busy <= 1'b0;
        end
        default: begin
          state <= SEQ_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_res <= 16'h0000;
      pend_flags <= FLAGS_RESET;
      pend_upd <= 8'h00;
      pend_hi <= 1'b0;
      pend_r0 <= 1'b0;
    end else if (issue && two_clk) begin
      pend_res <= r16;
      pend_flags <= nf;
      pend_upd <= upd;
      pend_hi <= next_wr_hi;
      pend_r0 <= next_to_r0;
    end
  end

  // ==================================================
  // result outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      res_valid <= 1'b0;
      res_lo <= 8'h00;
      res_hi <= 8'h00;
      res_wr_lo <= 1'b0;
      res_wr_hi <= 1'b0;
      res_to_r0 <= 1'b0;
    end else if (state == SEQ_SECOND) begin
      res_valid <= 1'b1;
      res_lo <= pend_res[7:0];
      res_hi <= pend_res[15:8];
      res_wr_lo <= 1'b1;
      res_wr_hi <= pend_hi;
      res_to_r0 <= pend_r0;
    end else if (issue && !two_clk) begin
      res_valid <= 1'b1;
      res_lo <= r8;
      res_hi <= dst_hi;
      res_wr_lo <= 1'b1;
      res_wr_hi <= 1'b0;
      res_to_r0 <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      res_wr_lo <= 1'b0;
      res_wr_hi <= 1'b0;
      res_to_r0 <= 1'b0;
    end
  end

  // flags: a hardware update wins over a software write to the same bit in one cycle
  logic [7:0] hw_upd;
  logic [7:0] hw_val;
  assign hw_upd = (state == SEQ_SECOND) ? pend_upd : ((issue && !two_clk) ? upd : 8'h00);
  assign hw_val = (state == SEQ_SECOND) ? pend_flags : nf;

  always_ff @(posedge clk) begin
    if (srst) begin
      status_flags <= FLAGS_RESET;
    end else begin
      status_flags <= (hw_upd & hw_val)
        | (~hw_upd & ((reg_wr && reg_addr == REG_STATUS_FLAGS) ? reg_wdata : status_flags));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      op_count <= 8'h00;
    end else if (issue) begin
      op_count <= op_count + 8'h01;
    end
  end

  // ==================================================
  // i/o address mapping
  logic next_legal;
  logic [7:0] next_daddr;
  logic [7:0] bit_mask;
  logic bit_now;

  assign bit_mask = 8'h01 << io_bit;
  assign bit_now = |(io_cur_value & bit_mask);

  always_comb begin
    next_legal = 1'b0;
    next_daddr = io_addr;
    case (io_kind)
      IO_TRANSFER: begin
        next_legal = io_addr <= IO_TRANSFER_LAST;
        next_daddr = io_addr + IO_DATA_OFFSET;
      end
      IO_DATA_ACCESS: begin
        next_legal = io_addr >= IO_DATA_OFFSET;
        next_daddr = io_addr;
      end
      IO_BIT_SET, IO_BIT_CLEAR, IO_SKIP_BIT_ONE, IO_SKIP_BIT_ZERO: begin
        next_legal = io_addr <= IO_BIT_LAST;
        next_daddr = io_addr + IO_DATA_OFFSET;
      end
      default: next_legal = 1'b0;
    endcase
  end

  // out-of-range addresses are guarded: io_ack still rises, but io_legal, the write mask and io_skip stay low
  always_ff @(posedge clk) begin
    if (srst) begin
      io_ack <= 1'b0;
      io_legal <= 1'b0;
      io_data_addr <= 8'h00;
      io_wmask <= 8'h00;
      io_wvalue <= 8'h00;
      io_skip <= 1'b0;
    end else begin
      io_ack <= io_valid;
      io_legal <= io_valid && next_legal;
      io_data_addr <= next_daddr;
      if (io_valid && next_legal && (io_kind == IO_BIT_SET || io_kind == IO_BIT_CLEAR)) begin
        io_wmask <= bit_mask;
        io_wvalue <= (io_kind == IO_BIT_SET) ? bit_mask : 8'h00;
      end else if (io_valid && next_legal && io_kind == IO_TRANSFER) begin
        io_wmask <= ALL_ONES;
        io_wvalue <= 8'h00;
      end else begin
        io_wmask <= (io_valid && next_legal && io_kind == IO_DATA_ACCESS) ? ALL_ONES : 8'h00;
        io_wvalue <= 8'h00;
      end
      io_skip <= io_valid && next_legal
        && ((io_kind == IO_SKIP_BIT_ONE && bit_now) || (io_kind == IO_SKIP_BIT_ZERO && !bit_now));
    end
  end

  // ==================================================
  // software register port
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STATUS_FLAGS: reg_rdata <= status_flags;
        REG_RESULT_LOW: reg_rdata <= res_lo;
        REG_RESULT_HIGH: reg_rdata <= res_hi;
        REG_OP_COUNT: reg_rdata <= op_count;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : aalo_core

// >>> include/aalo_pkg.sv
// constants for the arithmetic and logic datapath: op codes, flag positions, i/o map limits
// assumes the decoder presents one operation per cycle on a 5-bit op code
package aalo_pkg;
  // ==================================================
  // operation codes
  localparam logic [4:0] OP_ADD = 5'h00;
  localparam logic [4:0] OP_ADD_CARRY = 5'h01;
  localparam logic [4:0] OP_WORD_ADD_IMMEDIATE = 5'h02;
  localparam logic [4:0] OP_SUB = 5'h03;
  localparam logic [4:0] OP_SUB_CONSTANT = 5'h04;
  localparam logic [4:0] OP_SUB_WITH_BORROW = 5'h05;
  localparam logic [4:0] OP_SUB_CARRY_CONSTANT = 5'h06;
  localparam logic [4:0] OP_WORD_SUB_IMMEDIATE = 5'h07;
  localparam logic [4:0] OP_AND = 5'h08;
  localparam logic [4:0] OP_AND_CONSTANT = 5'h09;
  localparam logic [4:0] OP_OR = 5'h0a;
  localparam logic [4:0] OP_OR_CONSTANT = 5'h0b;
  localparam logic [4:0] OP_EXCLUSIVE_OR_REGS = 5'h0c;
  localparam logic [4:0] OP_ONES_COMPLEMENT = 5'h0d;
  localparam logic [4:0] OP_TWOS_COMPLEMENT = 5'h0e;
  localparam logic [4:0] OP_MASK_SET_BITS = 5'h0f;
  localparam logic [4:0] OP_MASK_CLEAR_BITS = 5'h10;
  localparam logic [4:0] OP_INCREMENT = 5'h11;
  localparam logic [4:0] OP_DECREMENT = 5'h12;
  localparam logic [4:0] OP_ZERO_MINUS_TEST = 5'h13;
  localparam logic [4:0] OP_REGISTER_ZERO = 5'h14;
  localparam logic [4:0] OP_REGISTER_ONES = 5'h15;
  localparam logic [4:0] OP_UNSIGNED_PRODUCT = 5'h16;
  localparam logic [4:0] OP_SIGNED_PRODUCT = 5'h17;
  localparam logic [4:0] OP_MIXED_SIGN_PRODUCT = 5'h18;
  // ==================================================
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  // ==================================================
  // i/o access kinds and address map
  localparam logic [2:0] IO_TRANSFER = 3'h0;
  localparam logic [2:0] IO_DATA_ACCESS = 3'h1;
  localparam logic [2:0] IO_BIT_SET = 3'h2;
  localparam logic [2:0] IO_BIT_CLEAR = 3'h3;
  localparam logic [2:0] IO_SKIP_BIT_ONE = 3'h4;
  localparam logic [2:0] IO_SKIP_BIT_ZERO = 3'h5;
  localparam logic [7:0] IO_BIT_LAST = 8'h1f;
  localparam logic [7:0] IO_TRANSFER_LAST = 8'h3f;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] IO_EXT_FIRST = 8'h60;
  // ==================================================
  // software register port
  localparam logic [1:0] REG_STATUS_FLAGS = 2'h0;
  localparam logic [1:0] REG_RESULT_LOW = 2'h1;
  localparam logic [1:0] REG_RESULT_HIGH = 2'h2;
  localparam logic [1:0] REG_OP_COUNT = 2'h3;
  // ==================================================
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_SECOND = 2'b10
  } aalo_state_e;
endpackage : aalo_pkg

// >>> tb/aalo_props.sv
// checker for the datapath: result timing, flag relations and the i/o address map
// assumes it is bound to aalo_core and sees its ports only
`timescale 1ns/1ns

module aalo_props
  import aalo_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic srst,
  // operations
  input logic op_valid,
  input logic [4:0] op_code,
  input logic busy,
  input logic res_valid,
  input logic res_wr_hi,
  input logic res_to_r0,
  input logic [7:0] res_lo,
  input logic [7:0] res_hi,
  input logic [7:0] status_flags,
  // i/o mapping
  input logic io_valid,
  input logic [2:0] io_kind,
  input logic [7:0] io_addr,
  input logic [2:0] io_bit,
  input logic io_ack,
  input logic io_legal,
  input logic [7:0] io_data_addr,
  input logic [7:0] io_wmask,
  input logic io_skip
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==================================================
  // helpers
  logic [4:0] last_code;
  logic taken;
  logic two_clk;
  assign taken = op_valid && !busy;
  assign two_clk = op_code inside {OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE,
    OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT};
  // reset to an unused code so no flag check fires before the first op
  always_ff @(posedge clk) begin
    if (srst) begin
      last_code <= 5'h1f;
    end else if (taken) begin
      last_code <= op_code;
    end
  end
  sequence s_hold;
    busy && !res_valid;
  endsequence
  sequence s_present;
    res_valid && !busy && res_wr_hi;
  endsequence
  // ==================================================
  // operations
  AST_ONE_CLOCK: assert property (taken && !two_clk && op_code <= OP_MIXED_SIGN_PRODUCT
    |=> res_valid && !busy && !res_wr_hi && !res_to_r0) else $error("one-clock op result late");
  AST_TWO_CLOCK: assert property (taken && two_clk |=> s_hold ##1 s_present)
    else $error("two-clock op result off");
  AST_PAIR_R0: assert property (taken && two_clk |-> ##2 res_to_r0 == (last_code >= OP_UNSIGNED_PRODUCT))
    else $error("fixed pair marker wrong");
  AST_ZERO_FLAG: assert property (res_valid && !res_wr_hi && last_code <= OP_MIXED_SIGN_PRODUCT
    && last_code != OP_REGISTER_ONES |-> status_flags[FLAG_Z] == (res_lo == 8'h00)
    && status_flags[FLAG_N] == res_lo[7]) else $error("zero or negative flag wrong");
  AST_WORD_ZERO: assert property (res_valid && res_wr_hi
    |-> status_flags[FLAG_Z] == ({res_hi, res_lo} == 16'h0000)) else $error("word zero flag wrong");
  AST_ONES_NO_FLAGS: assert property (res_valid && last_code == OP_REGISTER_ONES
    |-> res_lo == ALL_ONES && $stable(status_flags)) else $error("register set wrong");
  AST_CARRY_KEPT: assert property (res_valid && (last_code == OP_INCREMENT || last_code == OP_DECREMENT)
    |-> status_flags[FLAG_C] == $past(status_flags[FLAG_C])) else $error("carry changed");
  // ==================================================
  // i/o map
  AST_BIT_RANGE: assert property (io_valid && io_kind >= IO_BIT_SET && io_kind <= IO_SKIP_BIT_ZERO
    && io_addr > IO_BIT_LAST |=> io_ack && !io_legal && io_wmask == 8'h00 && !io_skip)
    else $error("bit access out of range allowed");
  AST_ONE_BIT: assert property (io_valid && (io_kind == IO_BIT_SET || io_kind == IO_BIT_CLEAR)
    && io_addr <= IO_BIT_LAST |=> io_legal && io_wmask == (8'h01 << $past(io_bit)))
    else $error("bit access mask wrong");
  AST_IO_OFFSET: assert property (io_valid && io_kind == IO_TRANSFER && io_addr <= IO_TRANSFER_LAST
    |=> io_legal && io_data_addr == $past(io_addr) + IO_DATA_OFFSET) else $error("transfer offset wrong");
  AST_EXT_ONLY_DATA: assert property (io_valid && io_addr >= IO_EXT_FIRST
    && (io_kind == IO_TRANSFER || io_kind == IO_DATA_ACCESS)
    |=> io_legal == ($past(io_kind) == IO_DATA_ACCESS)) else $error("extended range access wrong");
endmodule : aalo_props

// >>> tb/aalo_regfile.sv
// model of the register file beside the datapath, holding the fixed product pair
// assumes results arrive on the core's result ports, one per res_valid pulse
`timescale 1ns/1ns

module aalo_regfile (
  // clock
  input wire logic clk,
  // results from the core
  input wire logic res_valid,
  input wire logic res_to_r0,
  input wire logic [7:0] res_lo,
  input wire logic [7:0] res_hi,
  // fixed pair for products
  output logic [7:0] r0,
  output logic [7:0] r1
);
  // a product lands in r1:r0 whatever the operands were
  always_ff @(posedge clk) begin
    if (res_valid && res_to_r0) begin
      r0 <= res_lo;
      r1 <= res_hi;
    end
  end
endmodule : aalo_regfile

// >>> tb/aalo_core_tb.sv
// self-checking bench for the datapath: operations, i/o map and register port
// assumes aalo_pkg is compiled first; the checker is bound below
`timescale 1ns/1ns

module aalo_core_tb;
  import aalo_pkg::*;
  logic clk, srst, op_valid, io_valid, reg_wr, reg_rd;
  logic [4:0] op_code;
  logic [7:0] dst_lo, dst_hi, source_register, imm, io_addr, io_cur_value, reg_wdata, d;
  logic [2:0] io_kind, io_bit;
  logic [1:0] reg_addr;
  logic res_valid, res_wr_lo, res_wr_hi, res_to_r0, busy, io_ack, io_legal, io_skip;
  logic [7:0] res_lo, res_hi, status_flags, io_data_addr, io_wmask, io_wvalue, reg_rdata, r0, r1;
  int err_count = 0;
  int compares = 0;
  aalo_core dut_u (.clk, .srst, .op_valid, .op_code, .dst_lo, .dst_hi, .source_register, .imm,
    .res_valid, .res_lo, .res_hi, .res_wr_lo, .res_wr_hi, .res_to_r0, .busy, .status_flags,
    .io_valid, .io_kind, .io_addr, .io_bit, .io_cur_value, .io_ack, .io_legal, .io_data_addr,
    .io_wmask, .io_wvalue, .io_skip, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  aalo_regfile part_u (.clk, .res_valid, .res_to_r0, .res_lo, .res_hi, .r0, .r1);
  always #5 clk = ~clk;
  // ==================================================
  // compare and closing
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ==================================================
  // bus cycles
  task automatic run_op(input logic [4:0] c, input logic [7:0] hi, lo, b, input logic [15:0] e,
                        input int lat, input logic [7:0] fm, fe);
    int n;
    @(posedge clk);
    {op_valid, op_code, dst_hi, dst_lo, source_register, imm} <= {1'b1, c, hi, lo, b, b};
    @(posedge clk);
    op_valid <= 1'b0;
    n = 1;
    #1;
    while (res_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val(16'(n), 16'(lat));
    chk_val({res_hi, res_lo}, e);
    chk_val(16'(status_flags & fm), 16'(fe));
    chk_bit(res_wr_lo, 1'b1);
    chk_bit(res_wr_hi, lat == 2);
  endtask : run_op
  task automatic run_io(input logic [2:0] k, input logic [7:0] a, input logic [2:0] bt, input logic [7:0] cur,
                        input logic l, input logic [7:0] da, m, wv, input logic s);
    @(posedge clk);
    {io_valid, io_kind, io_addr, io_bit, io_cur_value} <= {1'b1, k, a, bt, cur};
    @(posedge clk);
    io_valid <= 1'b0;
    #1;
    chk_bit(io_ack, 1'b1);
    chk_bit(io_legal, l);
    if (l) chk_val(16'(io_data_addr), 16'(da));
    chk_val({io_wmask, io_wvalue}, {m, wv});
    chk_bit(io_skip, s);
  endtask : run_io
  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [1:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  // ==================================================
  // scenarios
  task automatic t_arith();
    run_op(OP_ADD, 8'h00, 8'h0f, 8'h01, 16'h0010, 1, 8'h2f, 8'h20);
    run_op(OP_ADD, 8'h00, 8'h80, 8'h80, 16'h0000, 1, 8'h2f, 8'h0b);
    run_op(OP_ADD_CARRY, 8'h00, 8'h01, 8'h01, 16'h0003, 1, 8'h2f, 8'h00);
    run_op(OP_SUB, 8'h00, 8'h10, 8'h01, 16'h000f, 1, 8'h2f, 8'h20);
    run_op(OP_SUB_CONSTANT, 8'h00, 8'h00, 8'h01, 16'h00ff, 1, 8'h2f, 8'h25);
    run_op(OP_SUB_WITH_BORROW, 8'h00, 8'h05, 8'h02, 16'h0002, 1, 8'h2f, 8'h00);
    run_op(OP_SUB_CARRY_CONSTANT, 8'h00, 8'h80, 8'h01, 16'h007f, 1, 8'h2f, 8'h28);
    $display("test arith done");
  endtask : t_arith
  task automatic t_word();
    // only six bits of the constant reach the pair
    run_op(OP_WORD_ADD_IMMEDIATE, 8'h00, 8'hff, 8'h41, 16'h0100, 2, 8'h1f, 8'h00);
    run_op(OP_WORD_ADD_IMMEDIATE, 8'h7f, 8'hff, 8'h01, 16'h8000, 2, 8'h1f, 8'h0c);
    run_op(OP_WORD_SUB_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'hffff, 2, 8'h1f, 8'h15);
    $display("test word done");
  endtask : t_word
  task automatic t_logic();
    run_op(OP_AND, 8'h00, 8'hf0, 8'h0f, 16'h0000, 1, 8'h0e, 8'h02);
    run_op(OP_AND_CONSTANT, 8'h00, 8'hf0, 8'hc0, 16'h00c0, 1, 8'h0e, 8'h04);
    run_op(OP_OR, 8'h00, 8'h00, 8'h00, 16'h0000, 1, 8'h0e, 8'h02);
    run_op(OP_OR_CONSTANT, 8'h00, 8'h01, 8'h80, 16'h0081, 1, 8'h0e, 8'h04);
    run_op(OP_EXCLUSIVE_OR_REGS, 8'h00, 8'haa, 8'haa, 16'h0000, 1, 8'h0e, 8'h02);
    run_op(OP_MASK_SET_BITS, 8'h00, 8'h01, 8'h02, 16'h0003, 1, 8'h0e, 8'h00);
    run_op(OP_MASK_CLEAR_BITS, 8'h00, 8'hff, 8'h0f, 16'h00f0, 1, 8'h0e, 8'h04);
    run_op(OP_ZERO_MINUS_TEST, 8'h00, 8'h80, 8'h00, 16'h0080, 1, 8'h0e, 8'h04);
    run_op(OP_REGISTER_ZERO, 8'h00, 8'h5a, 8'h00, 16'h0000, 1, 8'h0e, 8'h02);
    $display("test logic done");
  endtask : t_logic
  task automatic t_unary();
    run_op(OP_ONES_COMPLEMENT, 8'h00, 8'h0f, 8'h00, 16'h00f0, 1, 8'h0f, 8'h05);
    run_op(OP_TWOS_COMPLEMENT, 8'h00, 8'h01, 8'h00, 16'h00ff, 1, 8'h2f, 8'h25);
    run_op(OP_TWOS_COMPLEMENT, 8'h00, 8'h80, 8'h00, 16'h0080, 1, 8'h2f, 8'h0d);
    run_op(OP_INCREMENT, 8'h00, 8'h7f, 8'h00, 16'h0080, 1, 8'h0f, 8'h0d);
    run_op(OP_DECREMENT, 8'h00, 8'h80, 8'h00, 16'h007f, 1, 8'h0f, 8'h09);
    run_op(OP_DECREMENT, 8'h00, 8'h01, 8'h00, 16'h0000, 1, 8'h0f, 8'h03);
    run_op(OP_REGISTER_ONES, 8'h00, 8'h00, 8'h00, 16'h00ff, 1, 8'h0f, 8'h03);
    $display("test unary done");
  endtask : t_unary
  task automatic t_product();
    run_op(OP_UNSIGNED_PRODUCT, 8'h00, 8'hff, 8'hff, 16'hfe01, 2, 8'h03, 8'h01);
    run_op(OP_SIGNED_PRODUCT, 8'h00, 8'hff, 8'hff, 16'h0001, 2, 8'h03, 8'h00);
    @(posedge clk);
    #1;
    chk_val({r1, r0}, 16'h0001);
    run_op(OP_MIXED_SIGN_PRODUCT, 8'h00, 8'hff, 8'h02, 16'hfffe, 2, 8'h03, 8'h01);
    // the high byte stays readable after the pulse, distinct from the low byte here
    reg_read(REG_RESULT_HIGH);
    chk_val(16'(d), 16'h00ff);
    run_op(OP_UNSIGNED_PRODUCT, 8'h00, 8'h00, 8'h05, 16'h0000, 2, 8'h03, 8'h02);
    $display("test multiply done");
  endtask : t_product
  task automatic t_io();
    // port-like places are touched and so are out-of-range ones, which must come back refused
    run_io(IO_BIT_SET, 8'h05, 3'h3, 8'h00, 1'b1, 8'h25, 8'h08, 8'h08, 1'b0);
    run_io(IO_BIT_CLEAR, 8'h1f, 3'h7, 8'h00, 1'b1, 8'h3f, 8'h80, 8'h00, 1'b0);
    run_io(IO_BIT_SET, 8'h20, 3'h0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    run_io(IO_SKIP_BIT_ONE, 8'h03, 3'h2, 8'h04, 1'b1, 8'h23, 8'h00, 8'h00, 1'b1);
    run_io(IO_SKIP_BIT_ZERO, 8'h03, 3'h2, 8'h04, 1'b1, 8'h23, 8'h00, 8'h00, 1'b0);
    run_io(IO_SKIP_BIT_ZERO, 8'h20, 3'h2, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    run_io(IO_TRANSFER, 8'h3f, 3'h0, 8'h00, 1'b1, 8'h5f, 8'hff, 8'h00, 1'b0);
    run_io(IO_TRANSFER, 8'h60, 3'h0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    run_io(IO_DATA_ACCESS, 8'h60, 3'h0, 8'h00, 1'b1, 8'h60, 8'hff, 8'h00, 1'b0);
    run_io(IO_DATA_ACCESS, 8'h10, 3'h0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0);
    $display("test io done");
  endtask : t_io
  task automatic t_regs();
    reg_write(REG_STATUS_FLAGS, 8'hc0);
    reg_read(REG_STATUS_FLAGS);
    chk_val(16'(d), 16'h00c0);
    reg_write(REG_RESULT_LOW, 8'h77);
    reg_read(REG_RESULT_LOW);
    chk_val(16'(d), 16'h0000);
    reg_read(REG_OP_COUNT);
    chk_val(16'(d), 16'h001e);
    $display("test registers done");
  endtask : t_regs
  task automatic t_reset();
    // a reset in mid-run must clear flags, results and the op count
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    reg_read(REG_OP_COUNT);
    chk_val({d, status_flags}, 16'h0000);
    chk_val({res_hi, res_lo}, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // ==================================================
  // main sequence and watchdog
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {op_valid, io_valid, reg_wr, reg_rd, op_code, dst_lo, dst_hi, source_register, imm} = '0;
    {io_addr, io_cur_value, reg_wdata, io_kind, io_bit, reg_addr} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk_val(16'(status_flags), 16'h0000);
    t_arith();
    t_word();
    t_logic();
    t_unary();
    t_product();
    t_io();
    t_regs();
    t_reset();
    close_out();
  end
  // the whole run needs about 110 cycles
  initial begin
    #50000;
    err_count++;
    close_out();
  end
endmodule : aalo_core_tb

bind aalo_core aalo_props props_u (.clk, .srst, .op_valid, .op_code, .busy, .res_valid, .res_wr_hi,
  .res_to_r0, .res_lo, .res_hi, .status_flags, .io_valid, .io_kind, .io_addr, .io_bit, .io_ack,
  .io_legal, .io_data_addr, .io_wmask, .io_skip);
